// ---- sim/eag_effective_address_generator_sva.sv ----
// Port checker for the effective address generator.
// Assumes one clock domain and an answer one edge after each request.
`timescale 1ns/100ps
module eag_effective_address_generator_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic [3:0] mode_i,
    input wire logic [19:0] operand_i,
    input wire logic branch_taken_i,
    input wire logic [15:0] index_reg_x_i,
    input wire logic [3:0] x_extension_field_i,
    input wire logic [3:0] data_extension_field_i,
    input wire logic valid_o,
    input wire logic [19:0] addr_o,
    input wire logic uses_memory_o,
    input wire logic pc_load_o,
    input wire logic index_x_write_o,
    input wire logic [19:0] new_index_x_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_valid_follows: assert property (req_i |=> valid_o) else $error("no valid");
    chk_no_stray: assert property (
        !req_i |=> !valid_o && !pc_load_o && !index_x_write_o) else $error("stray pulse");
    chk_addr_holds: assert property (!req_i |=> $stable(addr_o)) else $error("addr moved");
    chk_ext_join: assert property (
        req_i && mode_i == eag_pkg::EAG_EXTENDED_MODE |=>
        addr_o == {$past(data_extension_field_i), $past(operand_i[15:0])})
        else $error("extended join");
    chk_long_ext: assert property (
        req_i && mode_i == eag_pkg::EAG_LONG_EXTENDED_MODE |=>
        addr_o == $past(operand_i)) else $error("long extended");
    chk_post_use: assert property (
        req_i && mode_i == eag_pkg::EAG_POST_MODIFIED_INDEX_MODE |=>
        index_x_write_o && addr_o == {$past(x_extension_field_i), $past(index_reg_x_i)})
        else $error("post use");
    chk_post_bank: assert property (
        index_x_write_o |-> new_index_x_o[19:16] == $past(x_extension_field_i))
        else $error("bank changed");
    chk_x_write_only: assert property (
        req_i && mode_i != eag_pkg::EAG_POST_MODIFIED_INDEX_MODE |=> !index_x_write_o)
        else $error("stray write-back");
    chk_branch_load: assert property (
        req_i && mode_i inside {eag_pkg::EAG_SHORT_BRANCH_MODE,
        eag_pkg::EAG_LONG_BRANCH_MODE} |=> pc_load_o == $past(branch_taken_i))
        else $error("branch load");
    chk_implied: assert property (
        req_i && mode_i == eag_pkg::EAG_IMPLIED_OPERAND_MODE |=>
        !uses_memory_o && addr_o == 20'h0_0000) else $error("implied");
endmodule : eag_effective_address_generator_sva
bind eag_effective_address_generator eag_effective_address_generator_sva i_chk (.*);

// ---- sim/effective_address_generator_test.sv ----
// Testbench: corner and random requests, each answer checked at the next falling edge.
// Assumes the design answers one rising edge after each request.
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module effective_address_generator_test;
    logic clk = 0, rstn = 0, req = 0, tk = 0, vld, mem, pld, xw;
    logic [3:0] mode = '0, xk = '0, yk = '0, zk = '0, dk = '0, pk = '0;
    logic [1:0] sel = '0;
    logic [15:0] x = '0, y = '0, z = '0, e = '0, pc = '0;
    logic [19:0] op = '0, addr, npc, nx, ex;
    logic [31:0] seed = 32'h0000_15DF, r;
    int bad_count = 0, total_checks = 0;
    eag_effective_address_generator i_dut (.clk_i(clk), .rstn_i(rstn), .req_i(req),
        .mode_i(mode), .index_sel_i(sel), .operand_i(op), .branch_taken_i(tk),
        .index_reg_x_i(x), .index_reg_y_i(y), .index_reg_z_i(z), .x_extension_field_i(xk),
        .y_extension_field_i(yk), .z_extension_field_i(zk), .data_extension_field_i(dk),
        .program_extension_field_i(pk), .acc_e_i(e), .pc_i(pc), .valid_o(vld), .addr_o(addr),
        .uses_memory_o(mem), .pc_load_o(pld), .new_pc_o(npc), .index_x_write_o(xw),
        .new_index_x_o(nx));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Sums are 20 bits wide, so bank carries and the top wrap fall out of the width
    function automatic logic [19:0] ea();
        logic [19:0] b;
        logic [19:0] p;
        b = sel == 2'b01 ? {yk, y} : sel == 2'b10 ? {zk, z} : {xk, x};
        p = {pk, pc};
        case (mode)
            4'h0: return b + {{4{e[15]}}, e};
            4'h1: return {dk, op[15:0]};
            4'h2: return op;
            4'h3, 4'h4: return p + 20'h0_0002;
            4'h5: return b + {12'h000, op[7:0]};
            4'h6: return b + {{4{op[15]}}, op[15:0]};
            4'h8: return 20'h0_0000;
            4'h9: return {xk, x};
            4'hA: return p + {{12{op[7]}}, op[7:0]};
            4'hB: return p + {{4{op[15]}}, op[15:0]};
            4'h7: return b + op;
            default: return b;
        endcase
    endfunction : ea
    // Called at a falling edge; leaves the request raised so calls run back to back
    task automatic go(input logic [3:0] m, input logic [1:0] s, input logic [19:0] o);
        mode = m;
        sel = s;
        op = o;
        req = 1;
        ex = ea();
        @(negedge clk);
        `CHK(vld, 1'b1)
        `CHK(addr, ex)
        `CHK(mem, 1'(!(m inside {4'h8, 4'hA, 4'hB})))
        `CHK(pld, 1'(tk && m inside {4'hA, 4'hB}))
        if (pld === 1'b1) `CHK(npc, ex)
        `CHK(xw, 1'(m == 4'h9))
        if (m == 4'h9) `CHK(nx, {xk, x + {{8{o[7]}}, o[7:0]}})
    endtask : go
    // Every output must sit at zero while reset is held and until a request
    task automatic chk_cleared();
        `CHK(vld, 1'b0)
        `CHK(addr, 20'h0_0000)
        `CHK(mem, 1'b0)
        `CHK(pld, 1'b0)
        `CHK(npc, 20'h0_0000)
        `CHK(xw, 1'b0)
        `CHK(nx, 20'h0_0000)
    endtask : chk_cleared
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (10) @(negedge clk);
        chk_cleared();
        rstn = 1;
        @(negedge clk);
        chk_cleared();
        y = 16'h0001;
        yk = 4'h3;
        go(4'h6, 2'b01, 20'h0_FFFE);
        x = 16'hFFFF;
        xk = 4'h2;
        go(4'h5, 2'b00, 20'h0_00FF);
        z = 16'hFFFF;
        zk = 4'hF;
        go(4'h7, 2'b10, 20'h0_0001);
        x = 16'h0000;
        go(4'h9, 2'b00, 20'h0_0080);
        e = 16'h8000;
        go(4'h0, 2'b10, 20'h0_0000);
        go(4'hF, 2'b10, 20'h0_0001);
        for (int i = 0; i < 600; i++) begin
            {x, y} = rnd();
            {z, e} = rnd();
            r = rnd();
            {pc, xk, yk, zk} = r[27:0];
            r = rnd();
            {dk, pk, tk, sel, op} = r[30:0];
            r = rnd();
            if (r[3:0] == 4'h0) begin
                req = 0;
                @(negedge clk);
                `CHK(vld, 1'b0)
            end
            go(r[7:4], sel, op);
        end
        // Reset in mid-run clears everything at once; work resumes on the next edge
        rstn = 0;
        req = 0;
        @(negedge clk);
        chk_cleared();
        rstn = 1;
        go(4'h1, 2'b00, 20'h0_1234);
        tally_and_finish();
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
endmodule : effective_address_generator_test

// ---- src/eag_adder20.sv ----
// 20-bit address adder: bank-joined base plus an already-extended offset.
// Assumes both operands are valid in the same cycle; purely combinational.
`timescale 1ns/100ps
module eag_adder20 (
    input wire logic [19:0] base_i,
    input wire logic [19:0] offset_i,
    output logic [19:0] sum_o
);
    logic [20:0] wide_sum;

    // Carry out of bit 15 reaches the upper nibble; carry out of bit 19 is dropped
    assign wide_sum = {1'b0, base_i} + {1'b0, offset_i}; // [RULE8]
    assign sum_o = wide_sum[19:0]; // [RULE14]
endmodule : eag_adder20

// ---- src/eag_effective_address_generator.sv ----
// Effective address generator: forms a 20-bit address for every addressing mode.
// Assumes decoder inputs, index registers and PC are steady in the request cycle.
`timescale 1ns/100ps
// Operation
// (RULE1) Nine addressing types are handled, with one or more variants in each.
// (RULE2) Accumulator offset: index X, Y or Z plus accumulator E.
// (RULE3) Short indexed: unsigned 8-bit offset added to chosen index register.
// (RULE4) Word indexed: signed 16-bit offset added to chosen index register.
// (RULE5) Long indexed: signed 20-bit offset added to X, Y or Z.
// (RULE6) Post-modified: use X unchanged first, then add signed byte to X.
// (RULE7) Each mode yields a 16-bit low address joined with a 4-bit upper part.
// (RULE8) Carry or borrow out of low 16 bits adjusts the upper nibble.
// (RULE9) Address computation never changes any extension field.
// (RULE10) Accumulator E is sign-extended to 20 bits before the addition.
// (RULE11) Taken branch adds signed byte or word offset to program bank and PC.
// (RULE12) Extended mode joins data extension field above the operand word.
// (RULE13) Immediate modes address the argument right after the instruction.
// (RULE14) All 20-bit sums wrap; carry out of bit 19 is discarded.
module eag_effective_address_generator (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic [3:0] mode_i,
    input wire logic [1:0] index_sel_i,
    input wire logic [19:0] operand_i,
    input wire logic branch_taken_i,
    input wire logic [15:0] index_reg_x_i,
    input wire logic [15:0] index_reg_y_i,
    input wire logic [15:0] index_reg_z_i,
    input wire logic [3:0] x_extension_field_i,
    input wire logic [3:0] y_extension_field_i,
    input wire logic [3:0] z_extension_field_i,
    input wire logic [3:0] data_extension_field_i,
    input wire logic [3:0] program_extension_field_i,
    input wire logic [15:0] acc_e_i,
    input wire logic [15:0] pc_i,
    output logic valid_o,
    output logic [19:0] addr_o,
    output logic uses_memory_o,
    output logic pc_load_o,
    output logic [19:0] new_pc_o,
    output logic index_x_write_o,
    output logic [19:0] new_index_x_o
);
    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    eag_pkg::eag_mode_e mode;
    logic [19:0] base;
    logic [19:0] offset;
    logic [19:0] sum;
    logic [19:0] x_joined;
    logic [19:0] y_joined;
    logic [19:0] z_joined;
    logic [19:0] pc_joined;
    logic [19:0] acc_sext;
    logic [19:0] byte_zext;
    logic [19:0] byte_sext;
    logic [19:0] word_sext;
    logic [19:0] post_sum;
    logic [19:0] next_addr;
    logic next_uses_memory;
    logic is_branch;
    logic is_post_modified;

    assign mode = eag_pkg::eag_mode_e'(mode_i);
    assign x_joined = {x_extension_field_i, index_reg_x_i};
    assign y_joined = {y_extension_field_i, index_reg_y_i};
    assign z_joined = {z_extension_field_i, index_reg_z_i};
    assign pc_joined = {program_extension_field_i, pc_i};

    // ------------------------------------------------------------
    // Offset extension
    // ------------------------------------------------------------
    // Every offset is widened to 20 bits before the add, so one adder
    // serves every address sum and bank carries reach the upper nibble for free
    assign acc_sext = {{4{acc_e_i[15]}}, acc_e_i};
    assign byte_zext = {12'h000, operand_i[7:0]};
    assign byte_sext = {{12{operand_i[7]}}, operand_i[7:0]};
    assign word_sext = {{4{operand_i[15]}}, operand_i[15:0]};

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign is_branch = (mode == eag_pkg::EAG_SHORT_BRANCH_MODE)
        || (mode == eag_pkg::EAG_LONG_BRANCH_MODE);
    assign is_post_modified = (mode == eag_pkg::EAG_POST_MODIFIED_INDEX_MODE);

    // ------------------------------------------------------------
    // Base selection
    // ------------------------------------------------------------
    // Base is the index register joined with its own extension field
    always_comb begin
        case (eag_pkg::eag_index_e'(index_sel_i))
            eag_pkg::EAG_SEL_Y: base = y_joined;
            eag_pkg::EAG_SEL_Z: base = z_joined;
            default: base = x_joined;
        endcase
        // Immediate and relative modes count from the program counter instead
        if (mode inside {eag_pkg::EAG_IMMEDIATE_BYTE_MODE, eag_pkg::EAG_IMMEDIATE_WORD_MODE,
            eag_pkg::EAG_SHORT_BRANCH_MODE, eag_pkg::EAG_LONG_BRANCH_MODE}) begin
            base = pc_joined; // [RULE11] [RULE13]
        end
    end

    // ------------------------------------------------------------
    // Offset selection
    // ------------------------------------------------------------
    always_comb begin
        offset = eag_pkg::ADDR_RST;
        case (mode) // [RULE1]
            eag_pkg::EAG_ACC_OFFSET_MODE: begin
                offset = acc_sext; // [RULE2] [RULE10]
            end
            eag_pkg::EAG_SHORT_INDEXED_MODE: begin
                offset = byte_zext; // [RULE3]
            end
            eag_pkg::EAG_WORD_INDEXED_MODE: begin
                offset = word_sext; // [RULE4]
            end
            eag_pkg::EAG_LONG_INDEXED_MODE: begin
                offset = operand_i; // [RULE5]
            end
            eag_pkg::EAG_IMMEDIATE_BYTE_MODE, eag_pkg::EAG_IMMEDIATE_WORD_MODE: begin
                // Argument sits right after the opcode word at the program counter
                offset = {4'h0, eag_pkg::WORD_ARG_STEP}; // [RULE13]
            end
            eag_pkg::EAG_SHORT_BRANCH_MODE: begin
                offset = byte_sext; // [RULE11]
            end
            eag_pkg::EAG_LONG_BRANCH_MODE: begin
                offset = word_sext; // [RULE11]
            end
            default: begin
                // Undefined codes fall back to the bare index register
                offset = eag_pkg::ADDR_RST;
            end
        endcase
    end

    eag_adder20 u_main_adder (
        .base_i(base),
        .offset_i(offset),
        .sum_o(sum)
    );

    // Post-increment of X uses its own adder so the address path stays short
    eag_adder20 u_post_adder (
        .base_i(x_joined),
        .offset_i(byte_sext),
        .sum_o(post_sum)
    ); // [RULE6]

    // ------------------------------------------------------------
    // Address result
    // ------------------------------------------------------------
    always_comb begin
        next_uses_memory = 1'b1;
        case (mode)
            eag_pkg::EAG_EXTENDED_MODE: begin
                next_addr = {data_extension_field_i, operand_i[15:0]}; // [RULE12] [RULE7]
            end
            eag_pkg::EAG_LONG_EXTENDED_MODE: begin
                next_addr = operand_i;
            end
            eag_pkg::EAG_POST_MODIFIED_INDEX_MODE: begin
                next_addr = x_joined; // [RULE6]
            end
            eag_pkg::EAG_IMPLIED_OPERAND_MODE: begin
                // Operands are internal resources; no memory access follows
                next_addr = eag_pkg::ADDR_RST;
                next_uses_memory = 1'b0;
            end
            eag_pkg::EAG_SHORT_BRANCH_MODE, eag_pkg::EAG_LONG_BRANCH_MODE: begin
                next_addr = sum;
                next_uses_memory = 1'b0;
            end
            default: begin
                next_addr = sum; // [RULE7] [RULE8]
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_o <= 1'b0;
            addr_o <= eag_pkg::ADDR_RST;
            uses_memory_o <= 1'b0;
        end else begin
            valid_o <= req_i;
            if (req_i) begin
                addr_o <= next_addr;
                uses_memory_o <= next_uses_memory;
            end
        end
    end

    // ------------------------------------------------------------
    // Branch target
    // ------------------------------------------------------------
    // Target follows every request; only the load pulse says it is taken
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_load_o <= 1'b0;
            new_pc_o <= eag_pkg::ADDR_RST;
        end else begin
            pc_load_o <= req_i && branch_taken_i && is_branch; // [RULE11]
            if (req_i) begin
                new_pc_o <= sum;
            end
        end
    end

    // ------------------------------------------------------------
    // Index write-back
    // ------------------------------------------------------------
    // Only X of the post-modified mode is written back; extension fields
    // stay untouched because no port carries a new value for them
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            index_x_write_o <= 1'b0;
            new_index_x_o <= eag_pkg::ADDR_RST;
        end else begin
            index_x_write_o <= req_i && is_post_modified; // [RULE6]
            if (req_i) begin
                new_index_x_o <= {x_extension_field_i, post_sum[15:0]}; // [RULE9]
            end
        end
    end
endmodule : eag_effective_address_generator

// ---- src/eag_pkg.sv ----
// Package for the effective address generator: mode codes, widths, reset values.
// Assumes a single core clock domain; no software-visible registers.
package eag_pkg;
    localparam int unsigned LOW_W = 16;
    localparam int unsigned EXT_W = 4;
    localparam int unsigned ADDR_W = 20;
    localparam logic [19:0] ADDR_RST = 20'h0_0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [3:0] FIELD_RST = 4'h0;
    localparam logic [15:0] BYTE_ARG_STEP = 16'h0001;
    localparam logic [15:0] WORD_ARG_STEP = 16'h0002;

    typedef enum logic [3:0] {
        EAG_ACC_OFFSET_MODE = 4'b0000,
        EAG_EXTENDED_MODE = 4'b0001,
        EAG_LONG_EXTENDED_MODE = 4'b0010,
        EAG_IMMEDIATE_BYTE_MODE = 4'b0011,
        EAG_IMMEDIATE_WORD_MODE = 4'b0100,
        EAG_SHORT_INDEXED_MODE = 4'b0101,
        EAG_WORD_INDEXED_MODE = 4'b0110,
        EAG_LONG_INDEXED_MODE = 4'b0111,
        EAG_IMPLIED_OPERAND_MODE = 4'b1000,
        EAG_POST_MODIFIED_INDEX_MODE = 4'b1001,
        EAG_SHORT_BRANCH_MODE = 4'b1010,
        EAG_LONG_BRANCH_MODE = 4'b1011
    } eag_mode_e;

    typedef enum logic [1:0] {
        EAG_SEL_X = 2'b00,
        EAG_SEL_Y = 2'b01,
        EAG_SEL_Z = 2'b10
    } eag_index_e;
endpackage : eag_pkg
